// file: logic/acs_sequencer.sv
// Conversion sequencer: start, timing, sample strobe and completion
// What this block does
// - The CPU clock is divided by a prescaler chosen by the divide select to give the converter clock.
// - The prescaler counts while the converter is enabled and is held in reset while it is disabled.
// - With auto trigger off, a software start begins the conversion at the next rising converter clock edge.
// - A normal conversion lasts 13 converter clock cycles from its start.
// - The first conversion after enabling lasts 25 converter clock cycles.
// - Sample-and-hold happens 1.5 cycles after a normal software start and 13.5 cycles after a first start.
// - At the end of each conversion the result is stored and the done flag set.
// - In single mode the start bit clears with the done flag and a new set starts again on the next edge.
// - An auto-trigger event resets the prescaler so trigger-to-start delay is fixed.
// - An auto-triggered normal sample lands two converter cycles after the synchronised trigger rising edge.
// - The trigger source passes three CPU clock stages first: two of synchronisation and one for edge detect.
// - In free-running mode a new conversion starts on completion and the start bit stays high.
// - Results span zero to two to the n minus one for an n-bit conversion.
`timescale 1ns/1ps
module acs_sequencer
	import acs_pkg::*;
(
	input  wire logic                    CLK,
	input  wire logic                    ARST_N,
	input  wire logic                    CONV_ENABLE,
	input  wire logic [DIV_SEL_BITS-1:0] CONV_CLK_DIV_SEL,
	input  wire logic                    CONV_START_SET,
	input  wire logic                    AUTO_TRIG_EN,
	input  wire logic                    FREE_RUN,
	input  wire logic                    TRIG_SRC,
	input  wire logic                    CONV_DONE_CLR,
	input  wire logic [RES_BITS-1:0]     ANA_RESULT,
	output logic                         CONV_START,
	output logic                         CONV_DONE_FLAG,
	output logic [RES_BITS-1:0]          CONV_RESULT,
	output logic                         SAMPLE_HOLD,
	output logic                         CONV_BUSY
);
	acs_state_t              state_q;
	logic                    start_q;
	logic                    done_q;
	logic                    first_q;
	logic [RES_BITS-1:0]     result_q;
	logic [CYC_BITS-1:0]     cyc_q;
	logic [TRIG_SYNC_CYCLES-1:0] trig_q;
	logic                    trig_edge;
	logic                    rise_tick;
	logic                    half_tick;
	logic                    complete;
	logic [CYC_BITS-1:0]     conv_len;
	logic [CYC_BITS-1:0]     sh_cycle;
	logic [CYC_BITS-1:0]     conv_last;
	logic                    auto_q;
	logic                    sh_tick;

	// Three stages: two to synchronise, one for edge detect
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			trig_q <= '0;
		else
			trig_q <= {trig_q[1:0], TRIG_SRC};
	end

	assign trig_edge = AUTO_TRIG_EN && CONV_ENABLE && trig_q[1] && !trig_q[2] && (state_q == ACS_IDLE);

	// Disabled or trigger event restarts the divider
	acs_prescaler u_pre
	(
		.clk       (CLK),
		.arst_n    (ARST_N),
		.hold_rst  (!CONV_ENABLE || trig_edge),
		.div_sel   (CONV_CLK_DIV_SEL),
		.rise_tick (rise_tick),
		.half_tick (half_tick)
	);

	assign conv_len = first_q ? FIRST_CYCLES : NORMAL_CYCLES;
	assign sh_cycle = first_q ? FIRST_SH_CYCLE : NORMAL_SH_CYCLE;
	// Start tick is cycle zero, so the tick that ends the last cycle completes
	assign conv_last = conv_len - 5'h01;
	assign complete  = (state_q == ACS_CONV) && rise_tick && (cyc_q == conv_last);

	// Sequencer state; free run chains straight into the next start
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			state_q <= ACS_IDLE;
		else if (!CONV_ENABLE)
			state_q <= ACS_IDLE;
		else
			case (state_q)
				ACS_IDLE:
					if (trig_edge)
						state_q <= ACS_CONV;
					else if (CONV_START_SET && !AUTO_TRIG_EN)
						state_q <= ACS_WAIT;
				ACS_WAIT:
					if (rise_tick)
						state_q <= ACS_CONV;
				ACS_CONV:
					if (complete && !FREE_RUN)
						state_q <= ACS_IDLE;
				default:
					state_q <= ACS_IDLE;
			endcase
	end

	// Cycle count since start edge; a trigger edge is itself the start
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			cyc_q <= CYC_RST;
		else if (state_q == ACS_WAIT && rise_tick)
			cyc_q <= CYC_RST;
		else if (trig_edge)
			cyc_q <= CYC_RST;
		else if (complete)
			cyc_q <= CYC_RST;
		else if (state_q == ACS_CONV && rise_tick)
			cyc_q <= cyc_q + 5'h01;
	end

	// Extra analog init on the first conversion after enable
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			first_q <= 1'b1;
		else if (!CONV_ENABLE)
			first_q <= 1'b1;
		else if (complete)
			first_q <= 1'b0;
	end

	// Start bit: stays up through a conversion, writes ignored while busy
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			start_q <= 1'b0;
		else if (!CONV_ENABLE)
			start_q <= 1'b0;
		else if (complete && !FREE_RUN)
			start_q <= 1'b0;
		else if (state_q == ACS_IDLE && CONV_START_SET && !AUTO_TRIG_EN)
			start_q <= 1'b1;
		else if (trig_edge)
			start_q <= 1'b1;
	end

	// Triggered normal start samples on a whole edge, not mid-period
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			auto_q <= 1'b0;
		else if (trig_edge)
			auto_q <= 1'b1;
		else if (state_q == ACS_IDLE && CONV_START_SET && !AUTO_TRIG_EN)
			auto_q <= 1'b0;
	end

	// Result captured at completion; width bounds the code range
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			result_q <= RESULT_RST;
		else if (complete)
			result_q <= ANA_RESULT;
	end

	// Completion flag; a new set beats a same-cycle clear
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			done_q <= 1'b0;
		else if (complete)
			done_q <= 1'b1;
		else if (CONV_DONE_CLR)
			done_q <= 1'b0;
	end

	// Sample strobe at the half-period after the chosen whole cycle, or at its end for a triggered normal start
	assign sh_tick     = (auto_q && !first_q) ? rise_tick : half_tick;
	assign SAMPLE_HOLD = (state_q == ACS_CONV) && sh_tick && (cyc_q == sh_cycle);

	assign CONV_START     = start_q || (state_q != ACS_IDLE);
	assign CONV_BUSY      = (state_q != ACS_IDLE);
	assign CONV_DONE_FLAG = done_q;
	assign CONV_RESULT    = result_q;

	property p_hold_when_off;
		@(posedge CLK) disable iff (!ARST_N)
		!CONV_ENABLE |=> !rise_tick && !CONV_BUSY;
	endproperty
	a_hold_when_off: assert property (p_hold_when_off) else $error("prescaler ran while disabled");

	property p_start_on_edge;
		@(posedge CLK) disable iff (!ARST_N)
		(state_q == ACS_WAIT && rise_tick && CONV_ENABLE) |=> (state_q == ACS_CONV && cyc_q == 5'h00);
	endproperty
	a_start_on_edge: assert property (p_start_on_edge) else $error("start missed converter edge");

	property p_len;
		@(posedge CLK) disable iff (!ARST_N)
		complete |-> (cyc_q == (first_q ? 5'h18 : 5'h0C));
	endproperty
	a_len: assert property (p_len) else $error("conversion length wrong");

	property p_first_cleared;
		@(posedge CLK) disable iff (!ARST_N)
		(complete && CONV_ENABLE) |=> !first_q;
	endproperty
	a_first_cleared: assert property (p_first_cleared) else $error("first flag not cleared");

	property p_sample_point;
		@(posedge CLK) disable iff (!ARST_N)
		SAMPLE_HOLD |-> (first_q ? (cyc_q == 5'h0D && half_tick) : (cyc_q == 5'h01 && (auto_q ? rise_tick : half_tick)));
	endproperty
	a_sample_point: assert property (p_sample_point) else $error("sample at wrong point");

	sequence s_done_write;
		CONV_DONE_FLAG && (CONV_RESULT == $past(ANA_RESULT));
	endsequence
	property p_done;
		@(posedge CLK) disable iff (!ARST_N)
		complete |=> s_done_write;
	endproperty
	a_done: assert property (p_done) else $error("result or flag not written");

	property p_single_clear;
		@(posedge CLK) disable iff (!ARST_N)
		(complete && !FREE_RUN && CONV_ENABLE) |=> !CONV_START && CONV_DONE_FLAG;
	endproperty
	a_single_clear: assert property (p_single_clear) else $error("start bit not cleared");

	property p_trig_restart;
		@(posedge CLK) disable iff (!ARST_N)
		trig_edge |=> (state_q == ACS_CONV) && (cyc_q == 5'h00) && !rise_tick;
	endproperty
	a_trig_restart: assert property (p_trig_restart) else $error("trigger did not restart");

	property p_sync_depth;
		@(posedge CLK) disable iff (!ARST_N)
		trig_edge |-> $past(TRIG_SRC, 2) && !$past(TRIG_SRC, 3);
	endproperty
	a_sync_depth: assert property (p_sync_depth) else $error("trigger sync depth wrong");

	property p_free_run;
		@(posedge CLK) disable iff (!ARST_N)
		(complete && FREE_RUN && CONV_ENABLE) |=> (state_q == ACS_CONV) && CONV_START;
	endproperty
	a_free_run: assert property (p_free_run) else $error("free run did not chain");

	property p_busy_reads_one;
		@(posedge CLK) disable iff (!ARST_N)
		CONV_BUSY |-> CONV_START;
	endproperty
	a_busy_reads_one: assert property (p_busy_reads_one) else $error("start bit low while busy");
endmodule

// file: logic/acs_pkg.sv
// Shared constants for the conversion sequencer
package acs_pkg;
	localparam int unsigned  CLK_FREQ_HZ     = 100_000_000;
	localparam int unsigned  RES_BITS        = 10;
	localparam int unsigned  DIV_SEL_BITS    = 3;
	localparam int unsigned  PRE_CNT_BITS    = 7;
	localparam int unsigned  CYC_BITS        = 5;
	// Converter clock cycles per conversion
	localparam logic [4:0]   NORMAL_CYCLES   = 5'h0D;
	localparam logic [4:0]   FIRST_CYCLES    = 5'h19;
	// Whole converter cycle before the half-cycle sample point
	localparam logic [4:0]   NORMAL_SH_CYCLE = 5'h01;
	localparam logic [4:0]   FIRST_SH_CYCLE  = 5'h0D;
	// Trigger synchroniser depth in CPU cycles
	localparam int unsigned  TRIG_SYNC_CYCLES = 3;
	// Reset values
	localparam logic [9:0]   RESULT_RST      = 10'h000;
	localparam logic [6:0]   PRE_CNT_RST     = 7'h00;
	localparam logic [4:0]   CYC_RST         = 5'h00;

	typedef enum logic [1:0]
	{
		ACS_IDLE  = 2'b00,
		ACS_WAIT  = 2'b01,
		ACS_CONV  = 2'b10
	} acs_state_t;
endpackage

// file: logic/acs_prescaler.sv
// Converter clock prescaler producing edge and mid-period ticks
`timescale 1ns/1ps
module acs_prescaler
	import acs_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	input  wire logic                    hold_rst,
	input  wire logic [DIV_SEL_BITS-1:0] div_sel,
	output logic                         rise_tick,
	output logic                         half_tick
);
	logic [PRE_CNT_BITS-1:0] cnt_q;
	logic [PRE_CNT_BITS-1:0] last;

	// Division factor minus one; selector 0 still divides by two
	function automatic logic [PRE_CNT_BITS-1:0] div_last(input logic [DIV_SEL_BITS-1:0] sel);
		logic [7:0] full;
		full = (sel == 3'h0) ? 8'h02 : (8'h01 << sel);
		div_last = PRE_CNT_BITS'(full - 8'h01);
	endfunction

	assign last = div_last(div_sel);

	// Held in reset while disabled or on trigger restart
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_q <= PRE_CNT_RST;
		else if (hold_rst)
			cnt_q <= PRE_CNT_RST;
		else if (cnt_q == last)
			cnt_q <= PRE_CNT_RST;
		else
			cnt_q <= cnt_q + 7'h01;
	end

	// Ticks are handshake-style strobes, so combinational is fine
	assign rise_tick = !hold_rst && (cnt_q == last);
	assign half_tick = !hold_rst && (cnt_q == (last >> 1));
endmodule

// file: bench/acs_ana_model.sv
// Analog core model: holds the level seen at the sample strobe
`timescale 1ns/1ps
module acs_ana_model
	import acs_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                arst_n,
	input  wire logic                sample_hold,
	input  wire logic [RES_BITS-1:0] level,
	output logic      [RES_BITS-1:0] code
);
	// Capture only on the strobe so later level changes cannot leak in
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			code <= 10'h000;
		else if (sample_hold)
			code <= level;
	end
endmodule

// file: bench/test_acs_sequencer.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module test_acs_sequencer;
	import acs_pkg::*;
	typedef struct {logic [9:0] val; int lo; int hi; int t0; bit rel;} acs_note_t;
	logic       clk, arst_n, en, start_set, auto_en, free_run, trig, done_clr;
	logic [2:0] div_sel;
	logic [9:0] level, code, result;
	logic       start, done, sh, busy, done_q;
	logic [31:0] rnd;
	int         fail_count, check_count, cyc, seed, d, last_t, trig_t;
	acs_note_t  notes[$];
	acs_note_t  nt;

	acs_sequencer u_acs_sequencer (.CLK(clk), .ARST_N(arst_n), .CONV_ENABLE(en), .CONV_CLK_DIV_SEL(div_sel),
		.CONV_START_SET(start_set), .AUTO_TRIG_EN(auto_en), .FREE_RUN(free_run), .TRIG_SRC(trig),
		.CONV_DONE_CLR(done_clr), .ANA_RESULT(code), .CONV_START(start), .CONV_DONE_FLAG(done),
		.CONV_RESULT(result), .SAMPLE_HOLD(sh), .CONV_BUSY(busy));
	acs_ana_model u_acs_ana_model (.clk(clk), .arst_n(arst_n), .sample_hold(sh), .level(level), .code(code));

	// Free-running 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk_val(string what, logic [9:0] exp, logic [9:0] got);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_win(string what, int lo, int hi, int got);
		check_count++;
		if (got < lo || got > hi)
		begin
			fail_count++;
			$display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Bounded wait for completion, then clear the sticky flag
	task automatic finish_conv();
		int n;
		n = 0;
		while (done !== 1'b1 && n < 3000)
		begin
			@(negedge clk);
			n++;
		end
		chk_val("done seen", 10'h001, {9'h000, done});
		@(posedge clk);
		done_clr <= 1'b1;
		@(posedge clk);
		done_clr <= 1'b0;
		@(negedge clk);
		chk_val("flag clear", 10'h000, {9'h000, done});
	endtask

	// One conversion by software or trigger; a stray start is tried while busy in the software case
	task automatic conv(logic [9:0] v, int len, bit trg);
		@(posedge clk);
		level <= v;
		notes.push_back('{v, len*d+1, len*d+d+(trg ? 6 : 3), cyc, 1'b0});
		if (trg)
			trig <= 1'b1;
		else
			start_set <= 1'b1;
		@(posedge clk);
		start_set <= 1'b0;
		trig <= 1'b0;
		@(posedge clk);
		start_set <= !trg;
		@(posedge clk);
		start_set <= 1'b0;
		@(negedge clk);
		chk_val("start while busy", 10'h001, {9'h000, start});
		finish_conv();
	endtask

	// Each new completion takes the oldest note off the queue
	always @(negedge clk)
	begin
		cyc = cyc + 1;
		if (trig === 1'b1)
			trig_t = cyc;
		if (sh === 1'b1 && auto_en === 1'b1)
			chk_win("sample delay", 2*d+1, 2*d+TRIG_SYNC_CYCLES, cyc-trig_t);
		if (done === 1'b1 && done_q !== 1'b1)
		begin
			if (notes.size() == 0)
				chk_val("completion count", 10'h000, 10'h001);
			else
			begin
				nt = notes.pop_front();
				chk_val("result", nt.val, result);
				chk_win("latency", nt.lo, nt.hi, cyc-(nt.rel ? last_t : nt.t0));
				chk_val("start bit", {9'h000, free_run}, {9'h000, start});
			end
			last_t = cyc;
		end
		done_q = done;
	end

	// Main sequence
	initial
	begin
		{arst_n, en, start_set, auto_en, free_run, trig, done_clr} = 7'h00;
		div_sel = 3'h1;
		level = 10'h000;
		{cyc, d, last_t, trig_t, fail_count, check_count} = {32'h0, 32'h2, 128'h0};
		done_q = 1'b0;
		seed = 32'h1c1873ef;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		en <= 1'b1;
		conv(10'h3FF, 25, 1'b0);
		conv(10'h000, 13, 1'b0);
		for (int k = 0; k < 4; k++)
		begin
			div_sel <= k[2:0];
			d = (k == 0) ? 2 : (1 << k);
			rnd = $random(seed);
			conv(rnd[9:0], 13, 1'b0);
		end
		@(posedge clk);
		start_set <= 1'b1;
		repeat (20) @(posedge clk);
		start_set <= 1'b0;
		en <= 1'b0;
		repeat (3) @(negedge clk);
		chk_val("busy after disable", 10'h000, {9'h000, busy});
		@(posedge clk);
		start_set <= 1'b1;
		@(posedge clk);
		start_set <= 1'b0;
		en <= 1'b1;
		conv(10'h155, 25, 1'b0);
		free_run <= 1'b1;
		conv(10'h2AA, 13, 1'b0);
		notes.push_back('{10'h2AA, 13*d, 13*d, 0, 1'b1});
		notes.push_back('{10'h2AA, 13*d, 13*d, 0, 1'b1});
		finish_conv();
		finish_conv();
		en <= 1'b0;
		free_run <= 1'b0;
		@(posedge clk);
		en <= 1'b1;
		div_sel <= 3'h2;
		d = 4;
		conv(10'h0F0, 25, 1'b0);
		auto_en <= 1'b1;
		rnd = $random(seed);
		conv(rnd[9:0], 13, 1'b1);
		conv(10'h3C3, 13, 1'b1);
		repeat (10) @(posedge clk);
		chk_val("notes left", 10'h000, notes.size());
		results();
	end

	// Watchdog far beyond the expected run length
	initial
	begin
		#400000;
		fail_count++;
		results();
	end
endmodule
